/* File: test/spi_host_model.sv */
// host serial controller that frames commands with chip select
// assumes a 6 ns link clock that stands low between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // serial link
   output var logic SCLK,
   output var logic CS_N,
   output var logic SI,
   input  wire logic SO
);
   // idle link; a deselect edge at start presets the link flops
   initial begin
      SCLK = 1'b0;
      SI   = 1'b0;
      CS_N = 1'b0;
      #1 CS_N = 1'b1;
   end
   // one frame: ntx bits msb first, then nrx bits taken at rising edges
   task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, output logic [127:0] rx);
      rx   = '0;
      CS_N = 1'b0;
      #4;
      for (int i = 0; i < ntx + nrx; i++) begin
         SI = (i < ntx) ? tx[ntx-1-i] : ~SI;  // no stale level after command
         #3 SCLK = 1'b1;
         if (i >= ntx) rx = {rx[126:0], SO};
         #3 SCLK = 1'b0;
      end
      #3 CS_N = 1'b1;
      #100;  // deselect gap covers command decode, not busy or recovery time
   endtask
endmodule
`default_nettype wire

/* File: test/spi_sec_core_assertions.sv */
// concurrent checks on the ports of the serial id / security block
// assumes the bind below attaches it to every spi_sec_core instance
`timescale 1ns/1ps
`default_nettype none
module spi_sec_core_assertions #(
   parameter int T_PROG_NS  = 20000,
   parameter int T_ERASE_NS = 40000,
   parameter int T_RST_NS   = 10000
) (
   // system
   input wire logic CLOCK,
   input wire logic RST_N,
   // link and status
   input wire logic CS_N,
   input wire logic SO,
   input wire logic SO_OE,
   input wire logic BUSY_FLAG,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic DEEP_POWER_DOWN,
   input wire logic RECOVERING,
   input wire logic RESET_DEFAULTS
);
   localparam int PC = (T_PROG_NS + 9) / 10 < 256 ? 256 : (T_PROG_NS + 9) / 10;
   localparam int EC = (T_ERASE_NS + 9) / 10 < 1024 ? 1024 : (T_ERASE_NS + 9) / 10;
   localparam int RC = (T_RST_NS + 9) / 10 < 1 ? 1 : (T_RST_NS + 9) / 10;
   int busy_cnt_r;
   int rec_cnt_r;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // length of the running busy stretch
   always_ff @(posedge CLOCK) begin
      busy_cnt_r <= (BUSY_FLAG && RST_N) ? busy_cnt_r + 1 : 0;
   end
   // length of the running recovery stretch
   always_ff @(posedge CLOCK) begin
      rec_cnt_r <= (RECOVERING && RST_N) ? rec_cnt_r + 1 : 0;
   end
   property p_busy_wel;
      $rose(BUSY_FLAG) |-> $past(WRITE_ENABLE_LATCH) || $past(WRITE_ENABLE_LATCH, 2);
   endproperty
   a_busy_wel: assert property (p_busy_wel) else $error("busy began without write enable");
   property p_wel_clear;
      $rose(BUSY_FLAG) |-> ##[0:1] !WRITE_ENABLE_LATCH;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("write enable kept in cycle");
   property p_busy_cs;
      $rose(BUSY_FLAG) |-> CS_N && $past(CS_N);
   endproperty
   a_busy_cs: assert property (p_busy_cs) else $error("cycle began while selected");
   property p_busy_len;
      $fell(BUSY_FLAG) && !RECOVERING |-> busy_cnt_r == PC || busy_cnt_r == EC;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_quiet;
      BUSY_FLAG |-> !SO_OE;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("output while busy");
   property p_rec_quiet;
      RECOVERING |-> !SO_OE && !BUSY_FLAG && !WRITE_ENABLE_LATCH;
   endproperty
   a_rec_quiet: assert property (p_rec_quiet) else $error("command taken in recovery");
   property p_rec_len;
      $fell(RECOVERING) |-> rec_cnt_r == RC;
   endproperty
   a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
   property p_defaults;
      RESET_DEFAULTS |=> !RESET_DEFAULTS && RECOVERING && !BUSY_FLAG && !WRITE_ENABLE_LATCH && !DEEP_POWER_DOWN;
   endproperty
   a_defaults: assert property (p_defaults) else $error("reset left state behind");
   property p_deselect;
      CS_N |-> !SO_OE && !SO;
   endproperty
   a_deselect: assert property (p_deselect) else $error("output while deselected");
endmodule
bind spi_sec_core spi_sec_core_assertions #(
   .T_PROG_NS(T_PROG_NS), .T_ERASE_NS(T_ERASE_NS), .T_RST_NS(T_RST_NS)
) u_chk (
   .CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .SO(SO), .SO_OE(SO_OE), .BUSY_FLAG(BUSY_FLAG),
   .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .DEEP_POWER_DOWN(DEEP_POWER_DOWN),
   .RECOVERING(RECOVERING), .RESET_DEFAULTS(RESET_DEFAULTS)
);
`default_nettype wire

/* File: test/test_spi_sec_core.sv */
// self-checking bench for the serial id / security block
// assumes the host model drives the link from its own timing
`timescale 1ns/1ps
`default_nettype none
module test_spi_sec_core;
   import spi_sec_pkg::*;
   logic         clock, rst_n, sclk, cs_n, si, so, so_oe, oe_seen;
   logic         lock1, lock2, lock3, busy, write_enable_latch, deep, recov, rdef;
   logic [127:0] r;
   int           err_count, checked, cycles, rdef_count;

   // design with shortened cycle times
   spi_sec_core #(.T_PROG_NS(2560), .T_ERASE_NS(10240), .T_RST_NS(2000)) u_dut (
      .CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
      .SECURE_AREA_LOCK_1(lock1), .SECURE_AREA_LOCK_2(lock2), .SECURE_AREA_LOCK_3(lock3),
      .BUSY_FLAG(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .DEEP_POWER_DOWN(deep),
      .RECOVERING(recov), .RESET_DEFAULTS(rdef)
   );
   spi_host_model u_host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so));

   // system clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // cycle ceiling and reset pulse count
   always @(negedge clock) begin
      cycles++;
      if (rdef === 1'b1) rdef_count++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test;
      end
   end
   // any output enable inside a frame
   always @(posedge sclk) if (so_oe === 1'b1) oe_seen = 1'b1;

   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tx(input logic [63:0] d, input int n, input int m);
      u_host.xfer(d, n, m, r);
   endtask
   // bounded wait on busy or recovery
   task automatic waitf(input logic v);
      int n;
      n = 0;
      while ((busy | recov) !== v && n < 1500) begin
         @(negedge clock);
         n++;
      end
      chk("busy_or_recovering", v, busy | recov);
   endtask
   task automatic prog(input logic [63:0] d, input int n);
      tx(64'(OP_WRITE_ENABLE_CMD), 8, 0);
      tx(d, n, 0);
      waitf(1'b1);
      waitf(1'b0);
   endtask

   task automatic t_ids;
      tx(64'(OP_JEDEC), 8, 32);
      chk("ident", {u_dut.MAKER_CODE, u_dut.TYPE_CODE, u_dut.SIZE_CODE, 8'h00}, r[31:0]);
      tx(64'({OP_MAKER_PART, 24'h000000}), 32, 16);
      chk("maker_part", {u_dut.MAKER_CODE, u_dut.PART_CODE}, r[15:0]);
      tx(64'({OP_UNIQUE, 32'h0}), 40, 128);
      chk("unique_id", u_dut.UNIQUE_ID, r);
      tx(64'(OP_JEDEC), 8, 3);
      chk("ident_cut", u_dut.MAKER_CODE[7:5], r[2:0]);
      chk("so_oe_idle", 1'b0, so_oe);
   endtask

   task automatic t_mem;
      tx(64'(OP_WRITE_ENABLE_CMD), 8, 0);
      chk("wel_set", 1'b1, write_enable_latch);
      tx(64'({OP_SEC_ERASE, 24'h001000}), 32, 0);
      waitf(1'b1);
      chk("wel_clear", 1'b0, write_enable_latch);
      oe_seen = 1'b0;
      tx(64'(OP_JEDEC), 8, 8);
      chk("quiet_busy", 1'b0, oe_seen);
      waitf(1'b0);
      prog(64'({OP_SEC_PROG, 24'h0013FF, 8'hA5}), 40);
      prog(64'({OP_SEC_PROG, 24'h0010FF, 16'h1122}), 48);
      tx(64'({OP_SEC_READ, 24'h0013FF, 8'h00}), 40, 24);
      chk("read_wrap", 24'hA522FF, r[23:0]);
      tx(64'({OP_SEC_READ, 24'h0010FF, 8'h00}), 40, 8);
      chk("read_page", 8'h11, r[7:0]);
   endtask

   task automatic t_refuse;
      logic [63:0] d [6];
      int          n [6];
      d = '{64'({OP_SEC_ERASE, 24'h001000, 1'b0}), 64'({OP_SEC_ERASE, 24'h001000}),
            64'({OP_SEC_ERASE, 24'h001400}), 64'({OP_SEC_ERASE, 24'h001000}),
            64'({OP_SEC_ERASE, 24'h002000}), 64'({OP_SEC_PROG, 24'h003000, 8'h00})};
      n = '{33, 32, 32, 32, 32, 40};
      for (int i = 0; i < 6; i++) begin
         @(negedge clock);
         {lock1, lock2, lock3} = {3{i > 2}};
         if (i != 1) tx(64'(OP_WRITE_ENABLE_CMD), 8, 0);
         tx(d[i], n[i], 0);
         repeat (20) @(negedge clock);
         chk("refused", 1'b0, busy);
         tx(64'(OP_WRDI), 8, 0);
      end
      @(negedge clock);
      {lock1, lock2, lock3} = 3'h0;
   endtask

   task automatic t_reset;
      waitf(1'b0);
      tx(64'(OP_WRITE_ENABLE_CMD), 8, 0);
      tx(64'(OP_RST_ENABLE), 8, 0);
      tx(64'(OP_JEDEC), 8, 0);
      tx(64'(OP_RST), 8, 0);
      chk("reset_disarmed", 1'b1, write_enable_latch);
      tx(64'(OP_RST_ENABLE), 8, 0);
      tx(64'(OP_RST), 8, 0);
      chk("reset_pulses", 1, rdef_count);
      chk("wel_reset", 1'b0, write_enable_latch);
      oe_seen = 1'b0;
      tx(64'(OP_JEDEC), 8, 8);
      chk("recovering", 1'b1, recov);
      chk("quiet_recovery", 1'b0, oe_seen);
      waitf(1'b0);
      tx(64'(OP_DEEP), 8, 0);
      chk("deep", 1'b1, deep);
      oe_seen = 1'b0;
      tx(64'({OP_MAKER_PART, 24'h000000}), 32, 8); // no 90h output while powered down
      chk("quiet_deep", 1'b0, oe_seen);
      tx(64'(OP_WRITE_ENABLE_CMD), 8, 0);
      chk("wel_deep", 1'b0, write_enable_latch);
      tx(64'(OP_RELEASE), 8, 0);
      chk("release", 1'b0, deep);
      tx(64'(OP_DEEP), 8, 0);
      chk("deep_again", 1'b1, deep);
      tx(64'(OP_RST_ENABLE), 8, 0);
      tx(64'(OP_RST), 8, 0);
      chk("deep_reset", 1'b0, deep);
      chk("reset_pulses", 2, rdef_count);
      waitf(1'b0);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // reset, then the scenarios in order
   initial begin
      rst_n = 1'b0;
      {lock1, lock2, lock3} = 3'h0;
      oe_seen = 1'b0;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      repeat (5) @(negedge clock);
      t_ids;
      t_mem;
      t_refuse;
      t_reset;
      end_of_test;
   end
endmodule
`default_nettype wire

/* File: verilog/spi_sec_core.sv */
// id reads, security area erase/program/read and software reset of a serial flash
// assumes SCLK idles outside frames and host keeps chip select high between commands
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) 90h plus zero address returns maker then part
// (R2) 9Fh returns maker, type, capacity bytes
// (R3) identification not decoded while busy
// (R4) host avoids identification in deep power-down
// (R5) chip select high ends output, standby
// (R6) 4Bh, address, dummy, then 128-bit unique value
// (R7) three independent 1024-byte security areas
// (R8) area chosen by address bits 15..12
// (R9) erase needs write enable latch set
// (R10) erase only when frame ends at bit 32
// (R11) erase busy self-timed, latch cleared
// (R12) locked area ignores erase
// (R13) program needs latch, address, data bytes
// (R14) program busy self-timed, latch cleared
// (R15) locked area ignores program
// (R16) 48h, address, dummy, data on falling edges
// (R17) read offset increments and wraps at 3FFh
// (R18) reset needs enable frame then reset frame
// (R19) reset aborts work, restores volatile defaults
// (R20) no command during reset recovery
// (R21) host checks busy before resetting
// (R22) program stays inside one 256-byte page
// (R23) extra data keeps last page of bytes
// (R24) deep power-down accepts only release, reset
// (R25) unique value msb first until deselect
module spi_sec_core
   import spi_sec_pkg::*;
#(
   parameter logic [7:0]   MAKER_CODE = 8'hA5,  // arbitrary value
   parameter logic [7:0]   PART_CODE  = 8'h3C,  // arbitrary value
   parameter logic [7:0]   TYPE_CODE  = 8'h5A,  // arbitrary value
   parameter logic [7:0]   SIZE_CODE  = 8'h18,  // arbitrary value
   parameter logic [127:0] UNIQUE_ID  = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, // arbitrary value
   parameter int           T_PROG_NS  = 20000,
   parameter int           T_ERASE_NS = 40000,
   parameter int           T_RST_NS   = 10000
) (
   // system
   input  wire logic CLOCK,
   input  wire logic RST_N,
   // serial link
   input  wire logic SCLK,
   input  wire logic CS_N,
   input  wire logic SI,
   output logic      SO,
   output logic      SO_OE,
   // lock bits
   input  wire logic SECURE_AREA_LOCK_1,
   input  wire logic SECURE_AREA_LOCK_2,
   input  wire logic SECURE_AREA_LOCK_3,
   // status
   output logic      BUSY_FLAG,
   output logic      WRITE_ENABLE_LATCH,
   output logic      DEEP_POWER_DOWN,
   output logic      RECOVERING,
   output logic      RESET_DEFAULTS
);
   // cycle counts, least time rounded up, never shorter than the copy loops
   localparam int PROG_RAW  = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_RAW = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_RAW   = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] PROG_CYC  = (PROG_RAW > PAGE_BYTES) ? 32'(PROG_RAW) : PAGE_END;
   localparam logic [31:0] ERASE_CYC = (ERASE_RAW > 1024) ? 32'(ERASE_RAW) : AREA_END;
   localparam logic [31:0] RST_CYC   = (RST_RAW > 1) ? 32'(RST_RAW) : 32'h0000_0001;
   // held value of a synchroniser: changes once stages two and three agree
   function automatic logic settle(input logic held, input logic s2, input logic s3);
      settle = (s2 == s3) ? s3 : held;
   endfunction
   // security storage, written by the system side, read by the link side; page buffer written by the link side, read by the system side
   logic [7:0]  sec_mem [0:MEM_BYTES-1];
   logic [7:0]  page_buf [0:PAGE_BYTES-1];

   // link domain
   logic            fresh_r;
   logic [15:0]     bits_r;
   logic [15:0]     bits_nxt;
   logic            over_r;
   logic [7:0]      shift_r;
   logic [7:0]      shift_nxt;
   logic [7:0]      opcode_r;
   logic [23:0]     addr_r;
   logic [7:0]      ptr_r;
   logic [255:0]    valid_r;
   logic            quiet1_r;
   logic            quiet2_r;
   logic            quiet3_r;
   logic            quiet_q_r;
   logic            so_r;
   logic            oe_r;
   logic            out_en;
   logic [7:0]      out_byte;
   logic [15:0]     start_bit;
   logic [15:0]     k;
   logic [1:0]      rd_area;
   logic [9:0]      rd_off;
   logic [1:0]      rd_area_m1;
   logic            quiet_sys_r;  // driven on the system side
   // marks the first clock of a frame; set while deselected
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   assign bits_nxt  = fresh_r ? 16'h0001 : (bits_r + 16'h0001);
   assign shift_nxt = {shift_r[6:0], SI};
   // input shifting on rising edges
   always_ff @(posedge SCLK) begin
      bits_r  <= bits_nxt;
      shift_r <= shift_nxt;
      over_r  <= fresh_r ? 1'b0 : (over_r | (bits_r == LEN_MAX));
      if (bits_nxt == LEN_CMD) begin
         opcode_r <= shift_nxt;
      end
      if (bits_nxt > LEN_CMD && bits_nxt <= LEN_ADDR) begin
         addr_r <= {addr_r[22:0], SI};
      end
   end
   // program data lands in the page buffer, wrapping in the page [R22] [R23]
   always_ff @(posedge SCLK) begin
      if (bits_nxt == LEN_CMD && shift_nxt == OP_SEC_PROG) begin
         valid_r <= '0;
      end
      if (bits_nxt == LEN_ADDR) begin
         ptr_r <= {addr_r[6:0], SI};
      end else if (opcode_r == OP_SEC_PROG && bits_nxt > LEN_ADDR && bits_nxt[2:0] == 3'h0) begin // [R13]
         page_buf[ptr_r] <= shift_nxt;
         valid_r[ptr_r]  <= 1'b1;
         ptr_r           <= ptr_r + 8'h01;
      end
   end
   // quiet level from the system side, three stages
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         quiet1_r  <= 1'b1;
         quiet2_r  <= 1'b1;
         quiet3_r  <= 1'b1;
         quiet_q_r <= 1'b1;
      end else begin
         quiet1_r  <= quiet_sys_r;
         quiet2_r  <= quiet1_r;
         quiet3_r  <= quiet2_r;
         quiet_q_r <= settle(quiet_q_r, quiet2_r, quiet3_r);
      end
   end
   // output phase start per opcode
   always_comb begin
      start_bit = LEN_MAX;
      case (opcode_r)
         OP_JEDEC:      start_bit = LEN_CMD;
         OP_MAKER_PART: start_bit = LEN_ADDR;
         OP_UNIQUE:     start_bit = LEN_DUMMY;
         OP_SEC_READ:   start_bit = LEN_DUMMY;
         default:       start_bit = LEN_MAX;
      endcase
   end

   assign k          = bits_r - start_bit;
   assign rd_area    = area_of(addr_r);
   assign rd_area_m1 = rd_area - 2'h1;
   assign rd_off     = addr_r[9:0] + k[12:3];  // wraps 3FFh to 000h [R17]
   // busy or powered-down device keeps the output off [R3] [R24]
   assign out_en     = !fresh_r && !quiet_q_r && bits_r >= start_bit && start_bit != LEN_MAX;
   // byte being shifted out
   always_comb begin
      out_byte = 8'h00;
      case (opcode_r)
         OP_JEDEC: begin  // [R2]
            case (k[15:3])
               13'h0000: out_byte = MAKER_CODE;
               13'h0001: out_byte = TYPE_CODE;
               13'h0002: out_byte = SIZE_CODE;
               default:  out_byte = 8'h00;
            endcase
         end
         OP_MAKER_PART: out_byte = k[3] ? PART_CODE : MAKER_CODE;  // [R1]
         OP_UNIQUE:     out_byte = UNIQUE_ID[8 * (15 - int'(k[6:3])) +: 8];  // [R6] [R25]
         OP_SEC_READ: begin  // [R16]
            if (rd_area != 2'h0) begin
               out_byte = sec_mem[{rd_area_m1, rd_off}];
            end else begin
               out_byte = 8'h00;
            end
         end
         default: out_byte = 8'h00;
      endcase
   end
   // output driven on falling edges, msb first; deselect ends it [R5]
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         so_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         so_r <= out_byte[3'h7 - k[2:0]];
         oe_r <= out_en;
      end
   end

   assign SO    = so_r;
   assign SO_OE = oe_r && !CS_N;

   // system domain
   logic        cs1_r;
   logic        cs2_r;
   logic        cs3_r;
   logic        cs_q_r;
   logic        cs_next;
   logic        fr1_r;
   logic        fr2_r;
   logic        fr3_r;
   logic        fr_q_r;
   logic        clocked_r;
   logic        frame_end;
   frame_type   frm;
   logic [1:0]  frm_area;
   logic        area_locked;
   logic        exact_cmd;
   state_type   state_r;
   logic [31:0] tcnt_r;
   logic [1:0]  area_r;
   logic [1:0]  page_r;
   logic        rst_en_r;
   logic        accept_reset;
   logic        start_erase;
   logic        start_prog;
   logic        wel_r;
   logic        deep_r;
   logic        defaults_r;
   logic [11:0] wr_idx;
   // chip select and first-clock marker, three stages each
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cs1_r  <= 1'b1;
         cs2_r  <= 1'b1;
         cs3_r  <= 1'b1;
         cs_q_r <= 1'b1;
         fr1_r  <= 1'b1;
         fr2_r  <= 1'b1;
         fr3_r  <= 1'b1;
         fr_q_r <= 1'b1;
      end else begin
         cs1_r  <= CS_N;
         cs2_r  <= cs1_r;
         cs3_r  <= cs2_r;
         cs_q_r <= cs_next;
         fr1_r  <= fresh_r;
         fr2_r  <= fr1_r;
         fr3_r  <= fr2_r;
         fr_q_r <= settle(fr_q_r, fr2_r, fr3_r);
      end
   end

   assign cs_next   = settle(cs_q_r, cs2_r, cs3_r);
   // a frame counts only if it carried at least one clock
   assign frame_end = !cs_q_r && cs_next && (clocked_r || !fr_q_r);
   // remember that the current frame saw a clock
   always_ff @(posedge CLOCK) begin
      if (!RST_N || frame_end) begin
         clocked_r <= 1'b0;
      end else if (!cs_q_r && !fr_q_r) begin
         clocked_r <= 1'b1;
      end
   end
   // link registers are stable while deselected
   assign frm         = '{opcode: opcode_r, addr: addr_r, bits: bits_r, over: over_r};
   assign frm_area    = area_of(frm.addr);  // [R8]
   assign exact_cmd   = frm.bits == LEN_CMD && !frm.over;
   assign area_locked = (frm_area == 2'h1 && SECURE_AREA_LOCK_1) ||
                        (frm_area == 2'h2 && SECURE_AREA_LOCK_2) ||
                        (frm_area == 2'h3 && SECURE_AREA_LOCK_3);
   // reset needs an enable frame directly before [R18] [R20]
   assign accept_reset = frame_end && frm.opcode == OP_RST && exact_cmd && rst_en_r &&
                         state_r != ST_RECOV;
   // erase ends exactly after the last address bit [R9] [R10] [R12]
   assign start_erase  = frame_end && state_r == ST_IDLE && !deep_r && wel_r &&
                         frm.opcode == OP_SEC_ERASE && frm.bits == LEN_ADDR && !frm.over &&
                         frm_area != 2'h0 && !area_locked;
   // program ends on a whole data byte [R13] [R15]
   assign start_prog   = frame_end && state_r == ST_IDLE && !deep_r && wel_r &&
                         frm.opcode == OP_SEC_PROG && frm.bits > LEN_ADDR &&
                         frm.bits[2:0] == 3'h0 && !frm.over &&
                         frm_area != 2'h0 && !area_locked;
   // reset enable armed by its own frame only
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         rst_en_r <= 1'b0;
      end else if (frame_end) begin
         rst_en_r <= frm.opcode == OP_RST_ENABLE && exact_cmd && state_r != ST_RECOV; // [R18]
      end
   end
   // self-timed cycles and reset recovery
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state_r <= ST_IDLE;
         tcnt_r  <= 32'h0000_0000;
         area_r  <= 2'h0;
         page_r  <= 2'h0;
      end else if (accept_reset) begin
         state_r <= ST_RECOV;  // abort any cycle [R19]
         tcnt_r  <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               tcnt_r <= 32'h0000_0000;
               area_r <= frm_area;
               page_r <= frm.addr[PAGE_LSB +: 2];
               if (start_erase) begin
                  state_r <= ST_ERASE;  // [R11]
               end else if (start_prog) begin
                  state_r <= ST_PROG;   // [R14]
               end
            end
            ST_PROG: begin
               tcnt_r <= tcnt_r + 32'h0000_0001;
               if (tcnt_r == PROG_CYC - 32'h0000_0001) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_ERASE: begin
               tcnt_r <= tcnt_r + 32'h0000_0001;
               if (tcnt_r == ERASE_CYC - 32'h0000_0001) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_RECOV: begin
               tcnt_r <= tcnt_r + 32'h0000_0001;
               if (tcnt_r == RST_CYC - 32'h0000_0001) begin
                  state_r <= ST_IDLE;  // [R20]
               end
            end
            default: begin
               state_r <= ST_IDLE;
               tcnt_r  <= 32'h0000_0000;
            end
         endcase
      end
   end
   // write enable latch and deep power-down
   always_ff @(posedge CLOCK) begin
      if (!RST_N || accept_reset) begin
         wel_r  <= 1'b0;  // [R19]
         deep_r <= 1'b0;
      end else if (start_erase || start_prog) begin
         wel_r  <= 1'b0;  // cleared before the cycle ends [R11] [R14]
      end else if (frame_end && state_r == ST_IDLE) begin
         if (deep_r) begin
            if (frm.opcode == OP_RELEASE) begin
               deep_r <= 1'b0;  // [R24]
            end
         end else if (exact_cmd && frm.opcode == OP_WRITE_ENABLE_CMD) begin
            wel_r <= 1'b1;
         end else if (exact_cmd && frm.opcode == OP_WRDI) begin
            wel_r <= 1'b0;
         end else if (exact_cmd && frm.opcode == OP_DEEP) begin
            deep_r <= 1'b1;
         end
      end
   end

   // defaults pulse and quiet level for the link
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         defaults_r  <= 1'b0;
         quiet_sys_r <= 1'b0;
      end else begin
         defaults_r  <= accept_reset;  // [R19]
         quiet_sys_r <= state_r != ST_IDLE || deep_r;  // [R3]
      end
   end

   // array updates: page copy ands into the area, erase fills ones [R7] [R22]
   assign wr_idx = (state_r == ST_PROG) ? {area_r - 2'h1, page_r, tcnt_r[7:0]} :
                                          {area_r - 2'h1, tcnt_r[9:0]};
   always_ff @(posedge CLOCK) begin
      if (state_r == ST_PROG && tcnt_r < PAGE_END && valid_r[tcnt_r[7:0]]) begin
         sec_mem[wr_idx] <= sec_mem[wr_idx] & page_buf[tcnt_r[7:0]];  // [R14]
      end else if (state_r == ST_ERASE && tcnt_r < AREA_END) begin
         sec_mem[wr_idx] <= ERASED_BYTE;  // [R11]
      end
   end

   assign BUSY_FLAG          = state_r == ST_PROG || state_r == ST_ERASE;
   assign WRITE_ENABLE_LATCH = wel_r;
   assign DEEP_POWER_DOWN    = deep_r;
   assign RECOVERING         = state_r == ST_RECOV;
   assign RESET_DEFAULTS     = defaults_r;

endmodule
`default_nettype wire

/* File: verilog/spi_sec_pkg.sv */
// constants, frame carrier and state codes for the serial id / security block
// assumes a host that selects the device with an active-low chip select
`default_nettype none
package spi_sec_pkg;
   // command opcodes
   localparam logic [7:0] OP_MAKER_PART = 8'h90;
   localparam logic [7:0] OP_JEDEC      = 8'h9F;
   localparam logic [7:0] OP_UNIQUE     = 8'h4B;
   localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
   localparam logic [7:0] OP_SEC_PROG   = 8'h42;
   localparam logic [7:0] OP_SEC_READ   = 8'h48;
   localparam logic [7:0] OP_RST_ENABLE = 8'h66;
   localparam logic [7:0] OP_RST        = 8'h99;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD       = 8'h06;
   localparam logic [7:0] OP_WRDI       = 8'h04;
   localparam logic [7:0] OP_DEEP       = 8'hB9;
   localparam logic [7:0] OP_RELEASE    = 8'hAB;
   // frame lengths in bits
   localparam logic [15:0] LEN_CMD   = 16'h0008;
   localparam logic [15:0] LEN_ADDR  = 16'h0020;
   localparam logic [15:0] LEN_DUMMY = 16'h0028;
   localparam logic [15:0] LEN_MAX   = 16'hFFFF;
   // address field positions
   localparam int SEL_LSB  = 12;
   localparam int PAD_LSB  = 10;
   localparam int HIGH_LSB = 16;
   localparam int PAGE_LSB = 8;
   // array geometry
   localparam int PAGE_BYTES = 256;
   localparam int MEM_BYTES  = 3072;
   localparam logic [31:0] PAGE_END = 32'h0000_0100;
   localparam logic [31:0] AREA_END = 32'h0000_0400;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   // system clock
   localparam int CLK_PERIOD_NS = 10;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [15:0] bits;
      logic        over;
   } frame_type;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_PROG  = 4'h2,
      ST_ERASE = 4'h4,
      ST_RECOV = 4'h8
   } state_type;

   // security area number 1..3 from an address, 0 when not a security address
   function automatic logic [1:0] area_of(input logic [23:0] a);
      logic [3:0] sel;
      sel = a[SEL_LSB +: 4];
      if (a[HIGH_LSB +: 8] != 8'h00 || a[PAD_LSB +: 2] != 2'h0) begin
         area_of = 2'h0;
      end else if (sel == 4'h1 || sel == 4'h2 || sel == 4'h3) begin
         area_of = sel[1:0];
      end else begin
         area_of = 2'h0;
      end
   endfunction
endpackage
`default_nettype wire
